// File: logic/ows_node.sv
// output node end: strap capture, driver update, readback and comms watchdog
`timescale 1ns/1ns
`include "ows_defines.svh"

module ows_node
  import ows_pkg::*;
#(
  parameter int unsigned WD_CYCLES = `OWS_WD_CYCLES
)
(
  // clock, reset, enable
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // straps, read once after reset
  input wire logic [`OWS_DIGIT_W-1:0] addr_ones_i,
  input wire logic [`OWS_DIGIT_W-1:0] addr_tens_i,
  input wire ows_kind_type kind_i,
  // link
  ows_link_if.node link,
  // current outputs: converter write port and readback
  output logic dac_wr_o,
  output logic [`OWS_CHAN_W-1:0] dac_chan_o,
  output logic [`OWS_DATA_W-1:0] dac_data_o,
  output logic current_en_o,
  input wire logic [`OWS_AO_CHANS-1:0][`OWS_DATA_W-1:0] adc_i,
  // relay outputs and contact readback
  output logic relay_load_o,
  output logic [`OWS_RELAYS-1:0] relay_o,
  output logic [`OWS_RELAYS-1:0] relay_led_o,
  output logic relay_en_o,
  input wire logic [`OWS_RELAYS-1:0] aux_i,
  // status
  output logic fault_led_o
);

  ows_node_type st_r;
  ows_node_type st_nxt;

  function automatic logic [`OWS_ADDR_W-1:0] bcd_addr(
    input logic [`OWS_DIGIT_W-1:0] tens,
    input logic [`OWS_DIGIT_W-1:0] ones
  );
    logic [`OWS_ADDR_W-1:0] t;
    t = {3'h0, tens};
    bcd_addr = 7'((t * `OWS_DEC_TENS) + {3'h0, ones});
  endfunction : bcd_addr

  function automatic logic off_tol(
    input logic [`OWS_DATA_W-1:0] a,
    input logic [`OWS_DATA_W-1:0] b
  );
    logic [`OWS_DATA_W-1:0] d;
    d = (a > b) ? 16'(a - b) : 16'(b - a);
    off_tol = d > `OWS_READBACK_TOL;
  endfunction : off_tol

  logic for_me;
  logic [`OWS_RELAYS-1:0] mismatch;

  assign for_me = st_r.strap_done && link.msg_valid && (link.msg_addr == st_r.addr);
  assign mismatch = st_r.aux ^ st_r.relay;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.xfer = 1'b0;
    st_nxt.rsp_valid = 1'b0;
    st_nxt.blink = 22'(st_r.blink + 22'h000001);
    st_nxt.aux = aux_i;
    if (!st_r.strap_done)
    begin
      // switches are read once; later changes need an nrst_i reset
      st_nxt.strap_done = 1'b1;
      st_nxt.addr = bcd_addr(addr_tens_i, addr_ones_i);
      st_nxt.kind = kind_i;
    end
    else if (for_me)
    begin
      unique case (link.msg_op)
        OWS_OP_RESET:
        begin
          st_nxt.halted = 1'b0;
          st_nxt.wrong_type = 1'b0;
        end
        OWS_OP_CLASH:
        begin
          st_nxt.halted = 1'b1;
        end
        OWS_OP_WRITE:
        begin
          // a node that is off or in conflict answers nothing
          if (!st_r.expired && !st_r.halted)
          begin
            st_nxt.rsp_valid = 1'b1;
            if (link.msg_kind != st_r.kind)
            begin
              // outputs left as they are; the watchdog will turn them off
              st_nxt.wrong_type = 1'b1;
              st_nxt.rsp_data = '0;
              st_nxt.rsp_status = 1'b1;
            end
            else if (st_r.kind == OWS_KIND_CURRENT)
            begin
              st_nxt.wrong_type = 1'b0;
              if (link.msg_chan < 3'(`OWS_AO_CHANS))
              begin
                st_nxt.xfer = 1'b1;
                st_nxt.dac_chan = link.msg_chan;
                st_nxt.dac_data = link.msg_data;
                st_nxt.dac_cmd[link.msg_chan] = link.msg_data;
                st_nxt.rsp_data = adc_i[link.msg_chan];
                st_nxt.rsp_status = off_tol(adc_i[link.msg_chan],
                                            st_r.dac_cmd[link.msg_chan]);
              end
              else
              begin
                st_nxt.rsp_data = '0;
                st_nxt.rsp_status = 1'b1;
              end
            end
            else
            begin
              st_nxt.wrong_type = 1'b0;
              st_nxt.xfer = 1'b1;
              st_nxt.relay = link.msg_data[`OWS_RELAYS-1:0];
              st_nxt.rsp_data = {mismatch, st_r.aux};
              st_nxt.rsp_status = |mismatch;
            end
          end
        end
        default:
        begin
          st_nxt.halted = st_r.halted;
        end
      endcase
    end
    // watchdog: restart on every converter or shift register transfer
    if (st_nxt.xfer)
    begin
      st_nxt.wd_cnt = '0;
    end
    else if (!st_r.expired)
    begin
      st_nxt.wd_cnt = 24'(st_r.wd_cnt + 24'h000001);
    end
    if (st_r.strap_done && ({8'h00, st_r.wd_cnt} > WD_CYCLES))
    begin
      // only nrst_i clears this; the node reset message does not
      st_nxt.expired = 1'b1;
    end
    if (st_r.expired)
    begin
      st_nxt.relay = '0;
      st_nxt.xfer = 1'b0;
      st_nxt.rsp_valid = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_r <= '0;
    end
    else if (ce_i)
    begin
      st_r <= st_nxt;
    end
  end

  assign link.rsp_valid = st_r.rsp_valid;
  assign link.rsp_addr = st_r.addr;
  assign link.rsp_kind = st_r.kind;
  assign link.rsp_data = st_r.rsp_data;
  assign link.rsp_status = st_r.rsp_status;

  assign dac_wr_o = st_r.xfer && (st_r.kind == OWS_KIND_CURRENT);
  assign dac_chan_o = st_r.dac_chan;
  assign dac_data_o = st_r.dac_data;
  assign current_en_o = st_r.strap_done && (st_r.kind == OWS_KIND_CURRENT)
                        && !st_r.expired && !st_r.halted;
  assign relay_load_o = st_r.xfer && (st_r.kind == OWS_KIND_RELAY);
  assign relay_en_o = st_r.strap_done && (st_r.kind == OWS_KIND_RELAY)
                      && !st_r.expired && !st_r.halted;
  assign relay_o = relay_en_o ? st_r.relay : '0;
  assign relay_led_o = relay_o;
  // steady when timed out, blinking on conflict or wrong-type data
  assign fault_led_o = st_r.expired
                       || ((st_r.halted || st_r.wrong_type)
                           && st_r.blink[`OWS_BLINK_W-1]);

endmodule : ows_node

// File: shared/ows_defines.svh
// constants shared by both ends of the output node watchdog link
`ifndef OWS_DEFINES_SVH
`define OWS_DEFINES_SVH

`define OWS_ADDR_W 7
`define OWS_DIGIT_W 4
`define OWS_DATA_W 16
`define OWS_CHAN_W 3
`define OWS_AO_CHANS 6
`define OWS_RELAYS 8
`define OWS_CLK_HZ 10000000
`define OWS_WD_TIMEOUT_MS 1200
`define OWS_WD_CYCLES (`OWS_WD_TIMEOUT_MS * (`OWS_CLK_HZ / 1000))
`define OWS_WD_W 24
`define OWS_BLINK_W 22
`define OWS_RESP_WIN 3'h4
`define OWS_CNT_W 3
`define OWS_READBACK_TOL 16'h0100
`define OWS_DEC_TENS 7'h0a

`endif

// File: shared/ows_pkg.sv
// types shared by both ends of the output node watchdog link
`include "ows_defines.svh"

package ows_pkg;

  typedef enum logic [1:0] {
    OWS_OP_WRITE = 2'b00,
    OWS_OP_CLASH = 2'b01,
    OWS_OP_RESET = 2'b10
  } ows_op_type;

  typedef enum logic {
    OWS_KIND_CURRENT = 1'b0,
    OWS_KIND_RELAY = 1'b1
  } ows_kind_type;

  typedef enum logic [1:0] {
    OWS_C_IDLE = 2'b00,
    OWS_C_SEND = 2'b01,
    OWS_C_WAIT = 2'b10,
    OWS_C_CLASH = 2'b11
  } ows_cstate_type;

  typedef struct packed {
    logic strap_done;
    logic [`OWS_ADDR_W-1:0] addr;
    ows_kind_type kind;
    logic [`OWS_WD_W-1:0] wd_cnt;
    logic expired;
    logic halted;
    logic wrong_type;
    logic [`OWS_RELAYS-1:0] relay;
    logic [`OWS_RELAYS-1:0] aux;
    logic xfer;
    logic [`OWS_CHAN_W-1:0] dac_chan;
    logic [`OWS_DATA_W-1:0] dac_data;
    logic [`OWS_AO_CHANS-1:0][`OWS_DATA_W-1:0] dac_cmd;
    logic rsp_valid;
    logic [`OWS_DATA_W-1:0] rsp_data;
    logic rsp_status;
    logic [`OWS_BLINK_W-1:0] blink;
  } ows_node_type;

  typedef struct packed {
    ows_cstate_type state;
    logic [`OWS_CNT_W-1:0] cnt;
    logic [1:0] hits;
    ows_kind_type rsp_kind;
    logic [`OWS_DATA_W-1:0] rsp_data;
    logic rsp_status;
    logic f_nomsg;
    logic f_addr;
    logic f_type;
    logic rd_valid;
    logic msg_valid;
    ows_op_type op;
    logic [`OWS_ADDR_W-1:0] addr;
    ows_kind_type kind;
    logic [`OWS_CHAN_W-1:0] chan;
    logic [`OWS_DATA_W-1:0] data;
  } ows_ctrl_type;

endpackage : ows_pkg

// File: shared/ows_link_if.sv
// link between the network controller end and an output node
`timescale 1ns/1ns
`include "ows_defines.svh"

interface ows_link_if;
  import ows_pkg::*;

  logic msg_valid;
  ows_op_type msg_op;
  logic [`OWS_ADDR_W-1:0] msg_addr;
  ows_kind_type msg_kind;
  logic [`OWS_CHAN_W-1:0] msg_chan;
  logic [`OWS_DATA_W-1:0] msg_data;
  logic rsp_valid;
  logic [`OWS_ADDR_W-1:0] rsp_addr;
  ows_kind_type rsp_kind;
  logic [`OWS_DATA_W-1:0] rsp_data;
  logic rsp_status;

  modport node (
    input msg_valid, msg_op, msg_addr, msg_kind, msg_chan, msg_data,
    output rsp_valid, rsp_addr, rsp_kind, rsp_data, rsp_status
  );

  modport ctrl (
    output msg_valid, msg_op, msg_addr, msg_kind, msg_chan, msg_data,
    input rsp_valid, rsp_addr, rsp_kind, rsp_data, rsp_status
  );
endinterface : ows_link_if

// File: logic/ows_ctrl.sv
// network controller end: polls a node and raises non-latching faults
`timescale 1ns/1ns
`include "ows_defines.svh"

module ows_ctrl
  import ows_pkg::*;
(
  // clock, reset, enable
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // user requests
  input wire logic poll_i,
  input wire logic reset_node_i,
  input wire logic [`OWS_ADDR_W-1:0] cfg_addr_i,
  input wire ows_kind_type cfg_kind_i,
  input wire logic [`OWS_CHAN_W-1:0] chan_i,
  input wire logic [`OWS_DATA_W-1:0] data_i,
  output logic busy_o,
  // results
  output logic rd_valid_o,
  output logic [`OWS_DATA_W-1:0] rd_data_o,
  output logic rd_status_o,
  output logic fault_nomsg_o,
  output logic fault_addr_o,
  output logic fault_type_o,
  // link
  ows_link_if.ctrl link
);

  ows_ctrl_type st_r;
  ows_ctrl_type st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.msg_valid = 1'b0;
    st_nxt.rd_valid = 1'b0;
    unique case (st_r.state)
      OWS_C_IDLE:
      begin
        if (reset_node_i || poll_i)
        begin
          st_nxt.state = OWS_C_SEND;
          st_nxt.msg_valid = 1'b1;
          st_nxt.op = reset_node_i ? OWS_OP_RESET : OWS_OP_WRITE;
          st_nxt.addr = cfg_addr_i;
          st_nxt.kind = cfg_kind_i;
          st_nxt.chan = chan_i;
          st_nxt.data = data_i;
          st_nxt.cnt = '0;
          st_nxt.hits = '0;
        end
      end
      OWS_C_SEND:
      begin
        if (st_r.op == OWS_OP_RESET)
        begin
          st_nxt.f_nomsg = 1'b0;
          st_nxt.state = OWS_C_IDLE;
        end
        else
        begin
          st_nxt.state = OWS_C_WAIT;
        end
      end
      OWS_C_WAIT:
      begin
        st_nxt.cnt = 3'(st_r.cnt + 3'h1);
        if (link.rsp_valid && (link.rsp_addr == st_r.addr))
        begin
          st_nxt.hits = (st_r.hits == 2'h3) ? st_r.hits : 2'(st_r.hits + 2'h1);
          st_nxt.rsp_kind = link.rsp_kind;
          st_nxt.rsp_data = link.rsp_data;
          st_nxt.rsp_status = link.rsp_status;
        end
        if (st_nxt.cnt == `OWS_RESP_WIN)
        begin
          // each poll overwrites all three faults, so none latches
          st_nxt.f_nomsg = (st_nxt.hits == 2'h0);
          st_nxt.f_addr = (st_nxt.hits > 2'h1);
          st_nxt.f_type = (st_nxt.hits == 2'h1)
                          && (st_nxt.rsp_kind != st_r.kind);
          st_nxt.rd_valid = (st_nxt.hits == 2'h1);
          st_nxt.state = (st_nxt.hits > 2'h1) ? OWS_C_CLASH : OWS_C_IDLE;
          st_nxt.msg_valid = (st_nxt.hits > 2'h1);
          st_nxt.op = OWS_OP_CLASH;
        end
      end
      OWS_C_CLASH:
      begin
        st_nxt.state = OWS_C_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_r <= '0;
    end
    else if (ce_i)
    begin
      st_r <= st_nxt;
    end
  end

  assign busy_o = (st_r.state != OWS_C_IDLE);
  assign rd_valid_o = st_r.rd_valid;
  assign rd_data_o = st_r.rsp_data;
  assign rd_status_o = st_r.rsp_status;
  assign fault_nomsg_o = st_r.f_nomsg;
  assign fault_addr_o = st_r.f_addr;
  assign fault_type_o = st_r.f_type;
  assign link.msg_valid = st_r.msg_valid;
  assign link.msg_op = st_r.op;
  assign link.msg_addr = st_r.addr;
  assign link.msg_kind = st_r.kind;
  assign link.msg_chan = st_r.chan;
  assign link.msg_data = st_r.data;

endmodule : ows_ctrl

// File: verification/ows_assertions.sv
// link checker: watches every signal between the controller and the node except msg_data
`timescale 1ns/1ns
`include "ows_defines.svh"

module ows_assertions
  import ows_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // controller to node
  input wire logic msg_valid,
  input wire ows_op_type msg_op,
  input wire logic [`OWS_ADDR_W-1:0] msg_addr,
  input wire ows_kind_type msg_kind,
  input wire logic [`OWS_CHAN_W-1:0] msg_chan,
  input wire logic [`OWS_DATA_W-1:0] msg_data,
  // node to controller
  input wire logic rsp_valid,
  input wire logic [`OWS_ADDR_W-1:0] rsp_addr,
  input wire ows_kind_type rsp_kind,
  input wire logic [`OWS_DATA_W-1:0] rsp_data,
  input wire logic rsp_status
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);

  AST_RSP_CAUSE: assert property (
    rsp_valid |-> $past(msg_valid && msg_op == OWS_OP_WRITE && msg_addr == rsp_addr))
    else $error("answer without a write to this address");
  AST_WRONG_KIND: assert property (
    rsp_valid && $past(msg_kind) != rsp_kind |-> rsp_status && rsp_data == 16'h0000)
    else $error("wrong kind write not refused");
  AST_BAD_CHAN: assert property (
    rsp_valid && rsp_kind == OWS_KIND_CURRENT && $past(msg_chan) > 3'h5 |-> rsp_status)
    else $error("channel above five not flagged");
  AST_RELAY_STATUS: assert property (
    rsp_valid && rsp_kind == OWS_KIND_RELAY && $past(msg_kind) == OWS_KIND_RELAY
      |-> rsp_status == (|rsp_data[15:8]))
    else $error("relay status disagrees with mismatch bits");
  AST_RSP_PULSE: assert property (
    rsp_valid |=> !rsp_valid)
    else $error("answer longer than one cycle");
  AST_STRAP_HOLD: assert property (
    msg_valid |=> $stable(rsp_addr) && $stable(rsp_kind))
    else $error("strapped address moved while running");
  AST_MSG_PULSE: assert property (
    msg_valid |=> !msg_valid)
    else $error("message longer than one cycle");
  AST_NO_ANSWER: assert property (
    msg_valid && msg_op != OWS_OP_WRITE |=> !rsp_valid)
    else $error("answer to a stop or reset message");
endmodule : ows_assertions

// File: verification/tb.sv
// self-checking bench: controller and node joined over the link
`timescale 1ns/1ns
`include "ows_defines.svh"

module tb import ows_pkg::*;;
  localparam int WD = 200;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic poll_i, node_rst, ce, busy, rdv, rds, fn, fa, ft, dwr, cen, rld, ren, fled;
  logic [`OWS_ADDR_W-1:0] cfg_addr;
  ows_kind_type cfg_kind, skind;
  logic [2:0] chan, dch;
  logic [15:0] data, rdd, ddat;
  logic [3:0] ones, tens;
  logic [5:0][15:0] adc;
  logic [7:0] aux, rly, led, old, mm;
  logic [31:0] seed;
  int failures, samples_checked, k, n_dwr, n_rld;
  int last [6];

  always #50 clock_i = ~clock_i;

  // strobes are counted away from the edge that launches them
  always @(negedge clock_i)
  begin
    if (dwr === 1'b1)
      n_dwr++;
    if (rld === 1'b1)
      n_rld++;
  end

  ows_link_if link ();
  ows_ctrl ows_ctrl_inst (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce), .poll_i(poll_i),
    .reset_node_i(node_rst), .cfg_addr_i(cfg_addr), .cfg_kind_i(cfg_kind), .chan_i(chan),
    .data_i(data), .busy_o(busy), .rd_valid_o(rdv), .rd_data_o(rdd), .rd_status_o(rds),
    .fault_nomsg_o(fn), .fault_addr_o(fa), .fault_type_o(ft), .link(link.ctrl));
  ows_node #(.WD_CYCLES(WD)) ows_node_inst (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce),
    .addr_ones_i(ones), .addr_tens_i(tens), .kind_i(skind), .link(link.node), .dac_wr_o(dwr),
    .dac_chan_o(dch), .dac_data_o(ddat), .current_en_o(cen), .adc_i(adc), .relay_load_o(rld),
    .relay_o(rly), .relay_led_o(led), .relay_en_o(ren), .aux_i(aux), .fault_led_o(fled));
  ows_assertions ows_assertions_inst (.clock_i(clock_i), .nrst_i(nrst_i),
    .msg_valid(link.msg_valid), .msg_op(link.msg_op), .msg_addr(link.msg_addr),
    .msg_kind(link.msg_kind), .msg_chan(link.msg_chan), .msg_data(link.msg_data),
    .rsp_valid(link.rsp_valid), .rsp_addr(link.rsp_addr), .rsp_kind(link.rsp_kind),
    .rsp_data(link.rsp_data), .rsp_status(link.rsp_status));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic nreset();
    nrst_i = 1'b0;
    repeat (5) @(posedge clock_i);
    #1;
    nrst_i = 1'b1;
    repeat (2) @(posedge clock_i);
    #1;
  endtask : nreset

  // poll when rs is low, node reset when high; returns once busy drops
  task automatic req(input logic rs);
    int i;
    poll_i = !rs;
    node_rst = rs;
    @(posedge clock_i);
    #1;
    poll_i = 1'b0;
    node_rst = 1'b0;
    for (i = 0; busy !== 1'b0; i++)
    begin
      if (i == 20)
      begin
        failures++;
        test_done();
      end
      @(posedge clock_i);
      #1;
    end
  endtask : req

  // one good write, expected values from the model of the strapped kind
  task automatic wr(input logic [2:0] ch);
    int e;
    chan = ch;
    data = 16'(xs());
    adc = {xs(), xs(), xs()};
    aux = 8'(xs());
    mm = aux ^ old;
    e = int'(adc[ch]) - last[ch];
    req(1'b0);
    chk("faults", 16'h0000, {13'h0000, fn, fa, ft});
    chk("rd_valid", 16'h0001, {15'h0000, rdv});
    if (skind == OWS_KIND_CURRENT)
    begin
      chk("rd_data", adc[ch], rdd);
      chk("rd_status", {15'h0000, e > 256 || e < -256}, {15'h0000, rds});
      chk("dac_data", data, ddat);
      chk("dac_chan", {13'h0000, ch}, {13'h0000, dch});
      last[ch] = data;
    end
    else
    begin
      chk("rd_data", {mm, aux}, rdd);
      chk("rd_status", {15'h0000, |mm}, {15'h0000, rds});
      chk("relay", {data[7:0], data[7:0]}, {rly, led});
      old = data[7:0];
    end
  endtask : wr

  initial
  begin
    {poll_i, node_rst, chan, data, adc, aux, old} = '0;
    ce = 1'b1;
    failures = 0;
    samples_checked = 0;
    n_dwr = 0;
    n_rld = 0;
    foreach (last[i])
      last[i] = 0;
    seed = 32'd51;
    tens = 4'h4;
    ones = 4'h2;
    skind = OWS_KIND_CURRENT;
    cfg_kind = OWS_KIND_CURRENT;
    cfg_addr = 7'h2a;
    nreset();
    for (k = 0; k < 12; k++)
      wr(3'(k % 6));
    chk("en_led", 16'h0002, {14'h0000, cen, fled});
    chk("dac_wr", 16'h000c, 16'(n_dwr));
    $display("test current writes done");
    chan = 3'h6;
    req(1'b0);
    chk("bad_chan", 16'h001a, {11'h000, rds, dch, fn});
    cfg_kind = OWS_KIND_RELAY;
    req(1'b0);
    chk("type_fault", 16'h0003, {14'h0000, ft, rds});
    chk("rd_data", 16'h0000, rdd);
    chk("dac_data", 16'(last[5]), ddat);
    cfg_kind = OWS_KIND_CURRENT;
    cfg_addr = 7'h2b;
    req(1'b0);
    chk("no_msg", 16'h0004, {12'h000, rdv, fn, fa, ft});
    cfg_addr = 7'h2a;
    req(1'b1);
    chk("no_msg", 16'h0000, {15'h0000, fn});
    tens = 4'h0;
    ones = 4'h7;
    wr(3'h0);
    $display("test refusals done");
    // writes spaced just inside the timeout must keep the drivers on
    repeat (WD - 20) @(posedge clock_i);
    #1;
    wr(3'h2);
    repeat (WD - 20) @(posedge clock_i);
    #1;
    chk("enable", 16'h0001, {15'h0000, cen});
    repeat (40) @(posedge clock_i);
    #1;
    chk("expired", 16'h0001, {14'h0000, cen, fled});
    req(1'b1);
    req(1'b0);
    chk("dead_node", 16'h0001, {15'h0000, fn});
    $display("test watchdog done");
    skind = OWS_KIND_RELAY;
    cfg_kind = OWS_KIND_RELAY;
    cfg_addr = 7'h07;
    nreset();
    for (k = 0; k < 8; k++)
      wr(3'h0);
    chk("relay_en", 16'h0001, {15'h0000, ren});
    chk("relay_load", 16'h0008, 16'(n_rld));
    // clock enable low must freeze the watchdog as well
    ce = 1'b0;
    repeat (WD + 20) @(posedge clock_i);
    #1;
    chk("frozen", 16'h0001, {15'h0000, ren});
    ce = 1'b1;
    repeat (WD + 20) @(posedge clock_i);
    #1;
    chk("relay_off", 16'h0000, {7'h00, ren, rly});
    chk("led_off", 16'h0000, {8'h00, led});
    $display("test relay node done");
    test_done();
  end
endmodule : tb
